// >>> erbs_bank_select.sv
// Emulation RAM bank select and write-enable decode
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module erbs_bank_select
  import erbs_pkg::*;
#(
  parameter logic [1:0] BUILD = ERBS_BUILD_4M
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic bus_clock_out_i,
  input wire erbs_bus_t bus_i,
  input wire erbs_jmp_t jmp_i,
  input wire logic ctrl_reset_n_i,
  input wire logic host_write_i,
  input wire logic selects_programmed_i,
  input wire logic user_selects_i,
  output logic [3:0] chip_en_o,
  output logic [3:0] hi_we_o,
  output logic [3:0] lo_we_o,
  output logic [3:0] bank_live_o,
  output logic [22:0] bank_size_o,
  output logic [2:0] bank_count_o,
  output logic rewrite_selects_o,
  output logic bank_disabled_o
);
  if (BUILD > ERBS_BUILD_4M) begin : g_bad_build
    $error("erbs_bank_select: unsupported BUILD");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers for pin inputs
  localparam int NSYNC = $bits(erbs_bus_t) + 2;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] stable_q;
  assign raw = {bus_i, bus_clock_out_i, ctrl_reset_n_i};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      stable_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts only once stages two and three agree
      stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
    end
  end

  erbs_bus_t sbus;
  logic bclk;
  logic creset_n;
  assign sbus = erbs_bus_t'(stable_q[NSYNC-1:2]);
  assign bclk = stable_q[1];
  assign creset_n = stable_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // Bus clock edge and controller reset tracking
  logic bclk_q;
  logic creset_q;
  logic bclk_rise;
  logic reset_rel;
  assign bclk_rise = bclk & ~bclk_q;
  assign reset_rel = creset_n & ~creset_q;

  erbs_state_t state_q;
  erbs_state_t state_d;
  logic [3:0] en_q;
  logic [3:0] en_d;
  logic rewrite_q;

  always_comb begin
    state_d = state_q;
    en_d = en_q;
    case (state_q)
      ERBS_ST_RESET: begin
        en_d = ERBS_EN_RESET;
        if (creset_n) begin
          state_d = ERBS_ST_BOOT;
        end
      end
      ERBS_ST_BOOT: begin
        // Only bank0 decodes until selects are reprogrammed
        en_d = ERBS_BANK0_MASK;
        if (selects_programmed_i) begin
          state_d = ERBS_ST_RUN;
        end
      end
      ERBS_ST_RUN: begin
        en_d = '1;
      end
      default: begin
        state_d = ERBS_ST_RESET;
        en_d = ERBS_EN_RESET;
      end
    endcase
    if (!creset_n) begin
      state_d = ERBS_ST_RESET;
      en_d = ERBS_EN_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bclk_q <= 1'b0;
      creset_q <= 1'b1;
      state_q <= ERBS_ST_RESET;
      en_q <= ERBS_EN_RESET;
      rewrite_q <= 1'b0;
    end else begin
      bclk_q <= bclk;
      creset_q <= creset_n;
      state_q <= state_d;
      en_q <= en_d;
      // Pulse host to rewrite user selects after each reset release, when user_selects_i is set
      rewrite_q <= reset_rel & user_selects_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [3:0] sel;
  logic [3:0] build_mask;
  logic [3:0] cfg_ok;
  logic [3:0] live;
  logic no_size_wide;
  logic strobe;
  logic wr;
  logic odd_byte;
  logic app_wp;
  logic [3:0] we_allow;

  // Each select line drives exactly one bank, except bank one's in wide mode without size lines
  assign sel = ~{sbus.bank3_select_n, sbus.bank2_select_n,
                 sbus.bank1_select_n, sbus.boot_select_n};
  // header wiring is transparent to the decode
  assign build_mask = (BUILD == ERBS_BUILD_256K) ? 4'h1 : 4'hF;
  assign no_size_wide = jmp_i.wide_width_jumper &
                        ~jmp_i.size_support_jumper;
  // Bank one serves as low-byte strobe in wide mode without size lines
  assign cfg_ok = {3'b111, 1'b1} &
                  ~{2'b00, no_size_wide, 1'b0};
  assign live = sel & jmp_i.bank_jumper & build_mask & cfg_ok & en_q;
  assign strobe = ~sbus.addr_strobe_n & ~sbus.data_strobe_n;
  assign wr = ~sbus.write_n;
  // Size lines: 8-bit transfer to odd address uses low lane only
  assign odd_byte = sbus.addr0 & sbus.transfer_size_lo &
                    ~sbus.transfer_size_hi;
  assign app_wp = jmp_i.write_protect_jumper & ~host_write_i;
  assign we_allow = {3'b111, ~app_wp};

  erbs_ram_t ram_d;
  always_comb begin
    ram_d.chip_en = '0;
    ram_d.hi_we = '0;
    ram_d.lo_we = '0;
    if (strobe) begin
      ram_d.chip_en = live;
      if (!jmp_i.wide_width_jumper) begin
        // 8-bit: high half only, same path with or without size lines
        ram_d.hi_we = wr ? (live & we_allow) : 4'h0;
        // size lines ignored in narrow mode
      end else if (no_size_wide) begin
        // Bank one select marks odd-byte writes on every bank but bank one
        ram_d.hi_we = (wr & ~sel[1]) ? (live & we_allow) : 4'h0;
        ram_d.lo_we = (wr & sel[1]) ?
                      (sel & jmp_i.bank_jumper & build_mask &
                       en_q & ~4'h2 & we_allow) : 4'h0;
        ram_d.chip_en = live | ram_d.lo_we;
      end else begin
        ram_d.hi_we = (wr & ~(odd_byte)) ? (live & we_allow) : 4'h0;
        ram_d.lo_we = (wr & (~sbus.addr0 | ~sbus.transfer_size_lo |
                       sbus.transfer_size_hi | odd_byte) &
                       ~(~sbus.addr0 & sbus.transfer_size_lo &
                       ~sbus.transfer_size_hi)) ?
                      (live & we_allow) : 4'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [2:0] count_d;
  assign count_d = (BUILD == ERBS_BUILD_256K) ? 3'h1 : 3'h4;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_en_o <= '0;
      hi_we_o <= '0;
      lo_we_o <= '0;
      bank_live_o <= '0;
      bank_size_o <= '0;
      bank_count_o <= '0;
      rewrite_selects_o <= 1'b0;
      bank_disabled_o <= 1'b1;
    end else begin
      chip_en_o <= ram_d.chip_en;
      hi_we_o <= ram_d.hi_we;
      lo_we_o <= ram_d.lo_we;
      bank_live_o <= jmp_i.bank_jumper & build_mask & cfg_ok & en_q;
      bank_size_o <= (BUILD == ERBS_BUILD_4M) ? ERBS_BANK_1M
                                               : ERBS_BANK_256K;
      bank_count_o <= count_d;
      rewrite_selects_o <= rewrite_q;
      // Host views show asterisks and loads fail while set
      bank_disabled_o <= (state_q != ERBS_ST_RUN);
    end
  end

  // Bus clock edges are tracked for later qualification
  logic unused;
  assign unused = bclk_rise;
endmodule
`default_nettype wire

// >>> erbs_bank_select_checker.sv
// Assertion checker for the bank-select decode
`timescale 1ns/1ps
`default_nettype none
module erbs_bank_select_checker
  import erbs_pkg::*;
#(
  parameter logic [1:0] BUILD = ERBS_BUILD_4M
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire erbs_jmp_t jmp_i,
  input wire logic ctrl_reset_n_i,
  input wire logic host_write_i,
  input wire logic selects_programmed_i,
  input wire logic user_selects_i,
  input wire logic [3:0] chip_en_o,
  input wire logic [3:0] hi_we_o,
  input wire logic [3:0] lo_we_o,
  input wire logic [3:0] bank_live_o,
  input wire logic [22:0] bank_size_o,
  input wire logic [2:0] bank_count_o,
  input wire logic rewrite_selects_o,
  input wire logic bank_disabled_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic [22:0] exp_size;
  wire logic [2:0] exp_cnt;
  assign exp_size = (BUILD == ERBS_BUILD_4M) ? ERBS_BANK_1M : ERBS_BANK_256K;
  assign exp_cnt = (BUILD == ERBS_BUILD_256K) ? 3'h1 : 3'h4;
  //////////////////////////////////////////////////////////////////////////
  ctrl_reset_off_a: assert property (!ctrl_reset_n_i [*8]
    |-> chip_en_o == 4'h0)
    else $error("bank enabled during controller reset");
  upper_banks_off_a: assert property (!selects_programmed_i [*8]
    |-> bank_disabled_o && bank_live_o[3:1] == 3'h0)
    else $error("upper bank live before selects programmed");
  jumper_gate_a: assert property (
    (chip_en_o & ~jmp_i.bank_jumper) == 4'h0)
    else $error("bank enabled without its jumper");
  bank1_nosize_a: assert property ((jmp_i.wide_width_jumper
    && !jmp_i.size_support_jumper) [*3]
    |-> !bank_live_o[1] && !chip_en_o[1])
    else $error("bank one live in wide mode without size support");
  write_protect_a: assert property ((jmp_i.write_protect_jumper
    && !host_write_i) [*6] |-> !hi_we_o[0] && !lo_we_o[0])
    else $error("application write reached protected bank zero");
  we_needs_en_a: assert property (
    ((hi_we_o | lo_we_o) & ~chip_en_o) == 4'h0)
    else $error("write enable without chip enable");
  build_size_a: assert property ($past(nrst_i) |-> bank_size_o == exp_size
    && bank_count_o == exp_cnt)
    else $error("bank size or count wrong for build");
  rewrite_pulse_a: assert property (rewrite_selects_o
    |-> user_selects_i ##1 !rewrite_selects_o)
    else $error("select rewrite pulse malformed");
  cover property (rewrite_selects_o);
  cover property (hi_we_o[0] && jmp_i.write_protect_jumper);
  cover property (chip_en_o[3] && lo_we_o[3]);
endmodule
bind erbs_bank_select erbs_bank_select_checker #(.BUILD(BUILD)) chk_i (.*);
`default_nettype wire

// >>> erbs_bank_select_tb.sv
// Self-checking testbench for the bank-select decode
`timescale 1ns/1ps
`default_nettype none
module erbs_bank_select_tb;
  import erbs_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  erbs_bus_t bus;
  logic bco;
  erbs_jmp_t jmp = 7'h7F;
  logic ctl_n = 1'b0;
  logic host = 1'b0;
  logic prog = 1'b0;
  logic user = 1'b1;
  logic [3:0] en, hwe, low_byte_write_enable, live;
  logic [22:0] size;
  logic [2:0] cnt;
  logic rw, dis;
  int err_count = 0;
  int num_checks = 0;
  int pulses = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (rw === 1'b1) pulses <= pulses + 1;
  erbs_pod_bus erbs_pod_bus_i (.clk_i(clk_i), .bus_o(bus), .bus_clock_out_o(bco));
  erbs_bank_select erbs_bank_select_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .bus_clock_out_i(bco), .bus_i(bus), .jmp_i(jmp), .ctrl_reset_n_i(ctl_n),
    .host_write_i(host), .selects_programmed_i(prog), .user_selects_i(user),
    .chip_en_o(en), .hi_we_o(hwe), .lo_we_o(low_byte_write_enable), .bank_live_o(live),
    .bank_size_o(size), .bank_count_o(cnt), .rewrite_selects_o(rw),
    .bank_disabled_o(dis));
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [22:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // Narrow mode puts every byte on the high lane
  function automatic logic [1:0] we_exp(logic wr, od, wd, blk);
    if (!wr || blk) return 2'h0;
    if (!jmp.wide_width_jumper) return 2'h2;
    if (wd) return 2'h3;
    return od ? 2'h1 : 2'h2;
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic xfer(input logic [1:0] b, input logic wr, od, wd, ok);
    logic [1:0] w;
    w = we_exp(wr, od, wd, b == 2'h0 && jmp.write_protect_jumper && !host);
    erbs_pod_bus_i.start(b, wr, od, wd);
    wait_n(8);
    chk(ok ? 4'h1 << b : 4'h0, en);
    chk(ok && w[1] ? 4'h1 << b : 4'h0, hwe);
    chk(ok && w[0] ? 4'h1 << b : 4'h0, low_byte_write_enable);
    erbs_pod_bus_i.stop();
    wait_n(8);
  endtask
  initial begin
    logic wd;
    void'($urandom(99355));
    wait_n(6);
    nrst_i = 1'b1;
    wait_n(4);
    ctl_n = 1'b1;
    wait_n(10);
    chk(23'(pulses), 23'h1);
    chk(live, 4'h1);
    chk(dis, 1'b1);
    chk(size, ERBS_BANK_1M);
    chk(cnt, 3'h4);
    xfer(2'h2, 1'b1, 1'b0, 1'b1, 1'b0);
    prog = 1'b1;
    wait_n(3);
    chk(dis, 1'b0);
    chk(live, 4'hF);
    for (int i = 0; i < 40; i++) begin
      wd = 1'($urandom);
      jmp.write_protect_jumper = 1'($urandom);
      host = 1'($urandom);
      if (i == 32) jmp.wide_width_jumper = 1'b0;
      xfer(2'($urandom), 1'($urandom), !wd && 1'($urandom), wd, 1'b1);
    end
    jmp.size_support_jumper = 1'b0;
    xfer(2'h1, 1'b1, 1'b1, 1'b0, 1'b1);
    jmp.wide_width_jumper = 1'b1;
    xfer(2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    chk(live[1], 1'b0);
    jmp.size_support_jumper = 1'b1;
    jmp.bank_jumper[3] = 1'b0;
    xfer(2'h3, 1'b1, 1'b0, 1'b1, 1'b0);
    user = 1'b0;
    ctl_n = 1'b0;
    wait_n(10);
    chk(en | live, 4'h0);
    ctl_n = 1'b1;
    wait_n(10);
    chk(23'(pulses), 23'h1);
    complete_run();
  end
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// >>> erbs_pkg.sv
// Package for the emulation RAM bank-select decode
package erbs_pkg;
  localparam int ERBS_NBANK = 4;
  localparam int ERBS_SYNC_W = 3;
  // Build sizes, bytes per bank
  localparam logic [1:0] ERBS_BUILD_256K = 2'h0;
  localparam logic [1:0] ERBS_BUILD_1M = 2'h1;
  localparam logic [1:0] ERBS_BUILD_4M = 2'h2;
  localparam logic [22:0] ERBS_BANK_256K = 23'h040000;
  localparam logic [22:0] ERBS_BANK_1M = 23'h100000;
  localparam logic [3:0] ERBS_EN_RESET = 4'h0;
  localparam logic [3:0] ERBS_BANK0_MASK = 4'h1;

  // Bus strobes, active low except transfer size and addr0 lines
  typedef struct packed {
    logic boot_select_n;
    logic bank1_select_n;
    logic bank2_select_n;
    logic bank3_select_n;
    logic addr_strobe_n;
    logic data_strobe_n;
    logic write_n;
    logic transfer_size_lo;
    logic transfer_size_hi;
    logic addr0;
  } erbs_bus_t;

  // Pod jumpers, 1 = fitted
  typedef struct packed {
    logic wide_width_jumper;
    logic size_support_jumper;
    logic write_protect_jumper;
    logic [3:0] bank_jumper;
  } erbs_jmp_t;

  typedef struct packed {
    logic [3:0] chip_en;
    logic [3:0] hi_we;
    logic [3:0] lo_we;
  } erbs_ram_t;

  typedef enum logic [1:0] {
    ERBS_ST_RESET = 2'b00,
    ERBS_ST_BOOT = 2'b01,
    ERBS_ST_RUN = 2'b10
  } erbs_state_t;
endpackage

// >>> erbs_pod_bus.sv
// Pod controller external bus model
`timescale 1ns/1ps
`default_nettype none
module erbs_pod_bus
  import erbs_pkg::*;
(
  input wire logic clk_i,
  output var erbs_bus_t bus_o,
  output logic bus_clock_out_o
);
  initial bus_o = 10'h3F8;
  initial bus_clock_out_o = 1'b0;
  always @(posedge clk_i) bus_clock_out_o <= ~bus_clock_out_o;
  // Each bank gets its own select, so address ranges never overlap
  task automatic start(input logic [1:0] b, input logic wr, od, wd);
    erbs_bus_t v;
    v = 10'h3FF;
    v[4'h9 - b] = 1'b0;
    v.addr_strobe_n = 1'b0;
    v.data_strobe_n = 1'b0;
    v.write_n = !wr;
    v.transfer_size_lo = !wd;
    v.transfer_size_hi = wd;
    v.addr0 = od;
    bus_o = v;
  endtask
  // Released lines go high and size and addr0 lines flip so stale values cannot pass
  task automatic stop();
    bus_o = {7'h7F, ~bus_o[2:0]};
  endtask
endmodule
`default_nettype wire
